// File: rtl/ldfs_pkg.sv
// constants and types for the load diagnostic and fault supervisor
package ldfs_pkg;
  // clock rate and timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned DIAG_MS = 229;
  localparam int unsigned DIAG_CYC = DIAG_MS * CLK_MHZ * 1000;
  localparam int unsigned DC_RESP_MS = 700;
  localparam int unsigned DC_CYC = DC_RESP_MS * CLK_MHZ * 1000;
  // check phase passes per diagnostic run
  localparam logic [2:0] DIAG_TRIES = 3'h5;
  // limiter setting register address and reset value
  localparam logic [7:0] LIMIT_REG_ADDR = 8'h03;
  localparam logic [1:0] LIMIT_RST = 2'h0;
  // symmetric output limit magnitudes per setting
  localparam logic signed [7:0] LIM_0 = 8'sh20;
  localparam logic signed [7:0] LIM_1 = 8'sh40;
  localparam logic signed [7:0] LIM_2 = 8'sh60;
  localparam logic signed [7:0] LIM_3 = 8'sh7f;
  // pwm half-period point, 50 percent duty
  localparam logic [7:0] PWM_MID = 8'h80;
  // status bit positions
  localparam int unsigned ST_GND = 0;
  localparam int unsigned ST_SUP = 1;
  localparam int unsigned ST_OPEN = 2;
  localparam int unsigned ST_ACROSS = 3;
  localparam int unsigned ST_OC = 4;
  localparam int unsigned ST_DC = 5;
  localparam int unsigned ST_OT = 6;
  localparam int unsigned ST_OV = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // supervisor states
  typedef enum logic [1:0] {LDFS_HOLD, LDFS_DIAG, LDFS_RUN, LDFS_PROT} ldfs_state_e;
endpackage

// File: rtl/ldfs_timer.sv
// restartable cycle counter with a one-cycle done pulse
`timescale 1ns/1ps
module ldfs_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // control
  input wire logic restart_i,
  input wire logic en_i,
  input wire logic [31:0] limit_i,
  // result
  output logic done_o
);
  logic [31:0] cnt_q, cnt_d;

  // count up while enabled, wrap at the limit
  always_comb begin
    done_o = 1'b0;
    cnt_d = cnt_q;
    if (restart_i) begin
      cnt_d = '0;
    end else if (en_i) begin
      if (cnt_q >= limit_i - 32'h1) begin
        done_o = 1'b1;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 32'h1;
      end
    end
  end

  // register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// File: rtl/ldfs_pwm.sv
// bridge duty modulator with symmetric output limit
`timescale 1ns/1ps
module ldfs_pwm (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // audio and limit
  input wire logic signed [7:0] level_i,
  input wire logic [1:0] limit_sel_i,
  // bridge switching
  output logic pos_o,
  output logic neg_o
);
  logic [7:0] cnt_q, cnt_d;
  logic pos_q, pos_d, neg_q, neg_d;
  logic signed [7:0] lim, lvl_c, half;
  logic [7:0] duty_p, duty_n;

  // clamp, then split into complementary duties
  always_comb begin
    case (limit_sel_i)
      2'h0: lim = ldfs_pkg::LIM_0;
      2'h1: lim = ldfs_pkg::LIM_1;
      2'h2: lim = ldfs_pkg::LIM_2;
      default: lim = ldfs_pkg::LIM_3;
    endcase
    lvl_c = level_i;
    if (level_i > lim) lvl_c = lim;
    if (level_i < -lim) lvl_c = -lim;
    half = lvl_c >>> 1;
    duty_p = 8'(ldfs_pkg::PWM_MID + $unsigned(half));
    duty_n = 8'(ldfs_pkg::PWM_MID - $unsigned(half));
    cnt_d = cnt_q + 8'h01;
    pos_d = cnt_q < duty_p;
    neg_d = cnt_q < duty_n;
  end

  // register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
    end
  end

  assign pos_o = pos_q;
  assign neg_o = neg_q;

  // zero input switches both legs together
  a_zero_in_phase: assert property (@(posedge clk_i) disable iff (!rstn_i)
    level_i == 8'sh00 && $stable(level_i) |=> pos_q == neg_q)
    else $error("bridge legs not in phase at zero input");
endmodule

// File: rtl/ldfs_supervisor.sv
// load diagnostic sequencer and protection supervisor for a bridge amplifier
`timescale 1ns/1ps

module ldfs_supervisor #(
  parameter int unsigned DIAG_CYCLES = ldfs_pkg::DIAG_CYC,
  parameter int unsigned DC_CYCLES = ldfs_pkg::DC_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // supply and mode indications
  input wire logic por_i,
  input wire logic standby_hold_i,
  input wire logic supply_low_protect_i,
  input wire logic supply_high_protect_i,
  input wire logic overcurrent_shutdown_i,
  input wire logic overtemperature_shutdown_i,
  input wire logic dc_offset_i,
  // load sense comparators
  input wire logic diag_short_gnd_i,
  input wire logic diag_short_supply_i,
  input wire logic diag_short_across_i,
  input wire logic diag_open_i,
  input wire logic diag_large_cap_i,
  // audio and limiter setting
  input wire logic signed [7:0] audio_level_i,
  input wire logic limit_wr_i,
  input wire logic [1:0] limit_sel_i,
  // bridge drive
  output logic bridge_hiz_o,
  output logic bridge_out_positive_o,
  output logic bridge_out_negative_o,
  // open-drain fault pin
  output logic fault_o,
  output logic fault_oe_o,
  // status and serial interface
  output logic [7:0] status_o,
  output logic [1:0] limit_o,
  output logic serial_release_o,
  output logic diag_busy_o
);
  ldfs_pkg::ldfs_state_e state_q, state_d;
  logic [2:0] tries_q, tries_d;
  logic [7:0] status_q, status_d;
  logic [1:0] limit_q, limit_d;
  logic hard_q, hard_d;
  logic ov_prev_q, ov_par_q, ov_par_d, skip_q, skip_d;
  logic hiz_q, hiz_d, pos_q, neg_q, fault_q, fault_d;
  logic rel_q, busy_q;
  logic diag_done, dc_done, pwm_p, pwm_n;
  logic prot_any, abort, hard_res, ov_rise, rst_all;

  // shared qualifiers
  assign rst_all = !rstn_i || por_i;
  assign prot_any = overcurrent_shutdown_i || overtemperature_shutdown_i
    || supply_low_protect_i || supply_high_protect_i;
  assign abort = overtemperature_shutdown_i || supply_high_protect_i
    || supply_low_protect_i;
  assign hard_res = diag_short_gnd_i || diag_short_supply_i || diag_short_across_i;
  assign ov_rise = supply_high_protect_i && !ov_prev_q;

  // diagnostic pass timer
  ldfs_timer u_diag_tmr (
    .clk_i(clk_i),
    .rstn_i(!rst_all),
    .restart_i(state_q != ldfs_pkg::LDFS_DIAG),
    .en_i(1'b1),
    .limit_i(32'(DIAG_CYCLES)),
    .done_o(diag_done)
  );

  // dc offset persistence timer, only while audio runs
  ldfs_timer u_dc_tmr (
    .clk_i(clk_i),
    .rstn_i(!rst_all),
    .restart_i(!dc_offset_i || state_q != ldfs_pkg::LDFS_RUN),
    .en_i(1'b1),
    .limit_i(32'(DC_CYCLES)),
    .done_o(dc_done)
  );

  // modulator
  ldfs_pwm u_pwm (
    .clk_i(clk_i),
    .rstn_i(!rst_all),
    .level_i(audio_level_i),
    .limit_sel_i(limit_q),
    .pos_o(pwm_p),
    .neg_o(pwm_n)
  );

  // sequencer next state
  always_comb begin
    state_d = state_q;
    tries_d = tries_q;
    hard_d = hard_q;
    skip_d = skip_q;
    ov_par_d = ov_par_q;
    if (ov_rise) begin
      ov_par_d = !ov_par_q;
    end
    case (state_q)
      ldfs_pkg::LDFS_HOLD: begin
        if (!standby_hold_i) begin
          state_d = ldfs_pkg::LDFS_DIAG;
          tries_d = '0;
        end
      end
      ldfs_pkg::LDFS_DIAG: begin
        if (abort) begin
          state_d = ldfs_pkg::LDFS_PROT;
          skip_d = 1'b0;
        end else if (diag_done) begin
          if ((hard_res || diag_large_cap_i) && tries_q < ldfs_pkg::DIAG_TRIES - 3'h1) begin
            tries_d = tries_q + 3'h1;
          end else if (hard_res) begin
            tries_d = '0;
            hard_d = 1'b1;
          end else begin
            state_d = ldfs_pkg::LDFS_RUN;
            hard_d = 1'b0;
          end
        end
      end
      ldfs_pkg::LDFS_RUN: begin
        if (prot_any || dc_done) begin
          state_d = ldfs_pkg::LDFS_PROT;
          // first overvoltage of a pair skips the diagnostic
          skip_d = ov_rise && !ov_par_q && !overcurrent_shutdown_i
            && !overtemperature_shutdown_i && !supply_low_protect_i;
        end
      end
      ldfs_pkg::LDFS_PROT: begin
        if (ov_rise) begin
          skip_d = 1'b0;
        end
        if (!prot_any) begin
          tries_d = '0;
          // automatic recovery once all shutdown and protect inputs are low; a dc offset trip does not wait for dc_offset_i
          state_d = skip_q ? ldfs_pkg::LDFS_RUN : ldfs_pkg::LDFS_DIAG;
        end
      end
      default: begin
        state_d = ldfs_pkg::LDFS_HOLD;
      end
    endcase
    if (standby_hold_i) begin
      state_d = ldfs_pkg::LDFS_HOLD;
    end
  end

  // sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      state_q <= ldfs_pkg::LDFS_HOLD;
      tries_q <= '0;
      hard_q <= 1'b0;
      skip_q <= 1'b0;
      ov_par_q <= 1'b0;
      ov_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tries_q <= tries_d;
      hard_q <= hard_d;
      skip_q <= skip_d;
      ov_par_q <= ov_par_d;
      ov_prev_q <= supply_high_protect_i;
    end
  end

  // status and control next values; status sets win over clears, undervoltage reset wins over a limiter write
  always_comb begin
    status_d = status_q;
    limit_d = limit_q;
    if (limit_wr_i) begin
      limit_d = limit_sel_i;
    end
    if (supply_low_protect_i) begin
      status_d = ldfs_pkg::STATUS_RST;
      limit_d = ldfs_pkg::LIMIT_RST;
    end
    if (state_q == ldfs_pkg::LDFS_PROT && state_d != ldfs_pkg::LDFS_PROT) begin
      status_d[ldfs_pkg::ST_OC] = 1'b0;
      status_d[ldfs_pkg::ST_DC] = 1'b0;
      status_d[ldfs_pkg::ST_OT] = 1'b0;
      status_d[ldfs_pkg::ST_OV] = 1'b0;
    end
    if (state_q == ldfs_pkg::LDFS_DIAG && diag_done && !abort) begin
      status_d[ldfs_pkg::ST_GND] = diag_short_gnd_i;
      status_d[ldfs_pkg::ST_SUP] = diag_short_supply_i;
      status_d[ldfs_pkg::ST_ACROSS] = diag_short_across_i;
      status_d[ldfs_pkg::ST_OPEN] = diag_open_i;
    end
    if (overcurrent_shutdown_i) status_d[ldfs_pkg::ST_OC] = 1'b1;
    if (dc_done) status_d[ldfs_pkg::ST_DC] = 1'b1;
    if (overtemperature_shutdown_i) status_d[ldfs_pkg::ST_OT] = 1'b1;
    if (supply_high_protect_i) status_d[ldfs_pkg::ST_OV] = 1'b1;
  end

  // status and control registers
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      status_q <= ldfs_pkg::STATUS_RST;
      limit_q <= ldfs_pkg::LIMIT_RST;
    end else begin
      status_q <= status_d;
      limit_q <= limit_d;
    end
  end

  // pin drive next values
  always_comb begin
    hiz_d = state_d != ldfs_pkg::LDFS_RUN;
    // open load alone never pulls the pin; a pulled pin stays low through recovery passes
    fault_d = prot_any || hard_d || state_d == ldfs_pkg::LDFS_PROT
      || (fault_q && state_d == ldfs_pkg::LDFS_DIAG);
  end

  // pin drive registers
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      hiz_q <= 1'b1;
      pos_q <= 1'b0;
      neg_q <= 1'b0;
      fault_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      hiz_q <= hiz_d;
      pos_q <= !hiz_d && pwm_p;
      neg_q <= !hiz_d && pwm_n;
      fault_q <= fault_d;
      busy_q <= state_d == ldfs_pkg::LDFS_DIAG;
    end
  end

  // serial release follows power-on reset only
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rel_q <= 1'b0;
    end else begin
      rel_q <= por_i;
    end
  end

  assign bridge_hiz_o = hiz_q;
  assign bridge_out_positive_o = pos_q;
  assign bridge_out_negative_o = neg_q;
  assign fault_o = 1'b0;
  assign fault_oe_o = fault_q;
  assign status_o = status_q;
  assign limit_o = limit_q;
  assign serial_release_o = rel_q;
  assign diag_busy_o = busy_q;

  // bridge stays floating during diagnostics
  a_hiz_in_diag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == ldfs_pkg::LDFS_DIAG && !por_i |-> bridge_hiz_o && !bridge_out_positive_o)
    else $error("bridge driven during diagnostics");

  // check phase count bounded
  a_tries_bound: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tries_q < ldfs_pkg::DIAG_TRIES)
    else $error("diagnostic retries exceed limit");

  // clean or open-only result starts audio next cycle
  a_clean_runs: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == ldfs_pkg::LDFS_DIAG && diag_done && !hard_res && !diag_large_cap_i && !abort
      && !standby_hold_i && !por_i && !prot_any
    |=> state_q == ldfs_pkg::LDFS_RUN && !bridge_hiz_o && !fault_oe_o)
    else $error("clean diagnostic did not start audio");

  // hard load fault reruns with the pin pulled
  a_hard_reruns: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == ldfs_pkg::LDFS_DIAG && diag_done && hard_res && !abort && !standby_hold_i && !por_i
      && tries_q == ldfs_pkg::DIAG_TRIES - 3'h1
    |=> state_q == ldfs_pkg::LDFS_DIAG && tries_q == 3'h0 && fault_oe_o && bridge_hiz_o)
    else $error("hard load fault not held");

  // abort diagnostics on thermal or supply fault
  a_diag_abort: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == ldfs_pkg::LDFS_DIAG && abort && !standby_hold_i && !por_i
    |=> state_q == ldfs_pkg::LDFS_PROT ##1 bridge_hiz_o)
    else $error("diagnostics not abandoned");

  // overcurrent floats the bridge and reports
  a_oc_shutdown: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == ldfs_pkg::LDFS_RUN && overcurrent_shutdown_i && !por_i
    |=> bridge_hiz_o && fault_oe_o && status_o[ldfs_pkg::ST_OC])
    else $error("overcurrent not handled");

  // undervoltage returns control to default
  a_uv_defaults: assert property (@(posedge clk_i) disable iff (!rstn_i)
    supply_low_protect_i && !por_i |=> limit_o == ldfs_pkg::LIMIT_RST && fault_oe_o)
    else $error("undervoltage did not reset control");

  // overvoltage reported in any mode
  a_ov_report: assert property (@(posedge clk_i) disable iff (!rstn_i)
    supply_high_protect_i && !por_i |=> status_o[ldfs_pkg::ST_OV] && fault_oe_o)
    else $error("overvoltage not reported");

  // power-on reset releases the serial interface
  a_por_release: assert property (@(posedge clk_i) disable iff (!rstn_i)
    por_i |=> serial_release_o && state_q == ldfs_pkg::LDFS_HOLD && status_o == ldfs_pkg::STATUS_RST)
    else $error("power-on reset not honoured");
endmodule

// File: testbench/ldfs_load_model.sv
// speaker load model: load sense levels and pulled-up fault wire
`timescale 1ns/1ps
module ldfs_load_model (
  // load condition chosen by the bench
  input wire logic [2:0] load_i,
  // fault pin drive from the device
  input wire logic fault_i,
  input wire logic fault_oe_i,
  // load sense levels
  output logic short_gnd_o,
  output logic short_supply_o,
  output logic short_across_o,
  output logic open_o,
  output logic large_cap_o,
  // resolved fault wire
  output logic fault_pin_o
);
  // 0 normal, 1 open, 2 gnd, 3 supply, 4 across, 5 large cap
  assign short_gnd_o = (load_i == 3'h2);
  assign short_supply_o = (load_i == 3'h3);
  assign short_across_o = (load_i == 3'h4);
  assign open_o = (load_i == 3'h1);
  assign large_cap_o = (load_i == 3'h5);
  // external pull-up holds the wire high when released
  assign fault_pin_o = fault_oe_i ? fault_i : 1'b1;
endmodule

// File: testbench/ldfs_supervisor_bench.sv
// self-checking bench for the load diagnostic and fault supervisor
`timescale 1ns/1ps
module ldfs_supervisor_bench;
  localparam int DN = 20;
  localparam int CN = 10;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic por = 1'b0, hold = 1'b1, uv = 1'b0, ov = 1'b0, oc = 1'b0, ot = 1'b0, dc = 1'b0;
  logic signed [7:0] lvl = 8'sh00;
  logic wr = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [2:0] load = 3'h0;
  logic hiz, pos, neg, flt, flt_oe, rel, busy, pin, sg, ss, sa, so, sc;
  logic [7:0] st;
  logic [1:0] lim;
  int mismatches = 0;
  int total_checks = 0;
  int a, b, c, d, e, f, k;
  logic [31:0] exp_q[$], act_q[$], me, ma;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  ldfs_supervisor #(.DIAG_CYCLES(DN), .DC_CYCLES(CN)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .por_i(por),
    .standby_hold_i(hold), .supply_low_protect_i(uv), .supply_high_protect_i(ov), .overcurrent_shutdown_i(oc),
    .overtemperature_shutdown_i(ot), .dc_offset_i(dc), .diag_short_gnd_i(sg), .diag_short_supply_i(ss),
    .diag_short_across_i(sa), .diag_open_i(so), .diag_large_cap_i(sc), .audio_level_i(lvl), .limit_wr_i(wr),
    .limit_sel_i(sel), .bridge_hiz_o(hiz), .bridge_out_positive_o(pos), .bridge_out_negative_o(neg),
    .fault_o(flt), .fault_oe_o(flt_oe), .status_o(st), .limit_o(lim), .serial_release_o(rel),
    .diag_busy_o(busy));

  ldfs_load_model load_u (.load_i(load), .fault_i(flt), .fault_oe_i(flt_oe), .short_gnd_o(sg),
    .short_supply_o(ss), .short_across_o(sa), .open_o(so), .large_cap_o(sc), .fault_pin_o(pin));

  // note an expected value with the observed one
  task automatic chk(input logic [31:0] ev, input logic [31:0] av);
    exp_q.push_back(ev);
    act_q.push_back(av);
  endtask

  // monitor takes the oldest notes and compares
  always @(negedge clk_i) begin
    while (exp_q.size() > 0) begin
      me = exp_q.pop_front();
      ma = act_q.pop_front();
      total_checks++;
      if (me !== ma) begin
        mismatches++;
        $display("Error t=%0t exp=%h got=%h", $time, me, ma);
      end
    end
  end

  function automatic logic pick(input int s);
    case (s)
      0: return hiz;
      1: return busy;
      2: return pin;
      default: return rel;
    endcase
  endfunction

  // bounded wait for an output level, then note it
  task automatic wait_for(input int s, input logic v, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(negedge clk_i);
      if (pick(s) === v) break;
    end
    chk({31'h0, v}, {31'h0, pick(s)});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr_limit(input logic [1:0] v);
    @(posedge clk_i);
    wr <= 1'b1;
    sel <= v;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  // overcurrent pulse of random length, then diagnostics restart
  task automatic oc_pulse();
    @(posedge clk_i);
    oc <= 1'b1;
    wait_for(0, 1'b1, 3);
    wait_for(2, 1'b0, 3);
    chk(32'h1, {31'h0, st[ldfs_pkg::ST_OC]});
    cyc(1 + $urandom % 4);
    oc <= 1'b0;
    wait_for(1, 1'b1, 4);
    chk(32'h0, {31'h0, pin});
  endtask

  // high-time counts of both legs over one pwm period
  task automatic duty(input logic signed [7:0] v, output int ph, output int nh, output int df);
    @(posedge clk_i);
    lvl <= v;
    cyc(512);
    ph = 0;
    nh = 0;
    df = 0;
    repeat (256) begin
      @(negedge clk_i);
      ph += int'(pos);
      nh += int'(neg);
      df += int'(pos !== neg);
    end
  endtask

  task automatic finish_test();
    cyc(2);
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog
  initial begin
    #(60000 * 10);
    mismatches++;
    finish_test();
  end

  // main sequence
  initial begin
    void'($urandom(32'h3e463d52));
    cyc(3);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    chk(32'h1, {31'h0, hiz});
    chk(32'h1, {31'h0, pin});
    chk(32'h0, {24'h0, st});
    @(posedge clk_i);
    hold <= 1'b0;
    wait_for(1, 1'b1, 4);
    repeat (DN - 3) @(negedge clk_i);
    chk(32'h3, {30'h0, busy, hiz});
    wait_for(0, 1'b0, 8);
    chk(32'h1, {31'h0, pin});
    $display("test hold_release done");

    k = 1 + $urandom % 3;
    wr_limit(k[1:0]);
    cyc(2);
    chk(k, {30'h0, lim});
    wr_limit(2'h0);
    duty(8'sh00, a, b, c);
    chk(0, c);
    duty(8'sh02 + 8'($urandom % 30), a, b, c);
    chk(32'h3, {30'h0, a > 128, b < 128});
    duty(-8'sh01 - 8'($urandom % 31), a, b, c);
    chk(32'h3, {30'h0, b > 128, a < 128});
    duty(8'sh7f, a, b, c);
    duty(8'sh20, d, e, f);
    chk(a, d);
    duty(-8'sh80, d, e, f);
    chk(a, e);
    $display("test pwm done");

    cyc(1);
    ov <= 1'b1;
    wait_for(2, 1'b0, 4);
    chk(32'h1, {31'h0, st[ldfs_pkg::ST_OV]});
    @(posedge clk_i);
    ov <= 1'b0;
    wait_for(0, 1'b0, 6);
    chk(32'h0, {31'h0, busy});
    cyc(1);
    ov <= 1'b1;
    cyc(2);
    ov <= 1'b0;
    wait_for(1, 1'b1, 6);
    @(posedge clk_i);
    ot <= 1'b1;
    wait_for(1, 1'b0, 4);
    wait_for(2, 1'b0, 3);
    chk(32'h3, {30'h0, hiz, st[ldfs_pkg::ST_OT]});
    cyc(5);
    ot <= 1'b0;
    wait_for(0, 1'b0, 2 * DN + 10);
    $display("test ov_ot done");

    @(posedge clk_i);
    load <= 3'h1;
    oc_pulse();
    wait_for(0, 1'b0, DN + 8);
    chk(32'h5, {29'h0, st[ldfs_pkg::ST_OPEN], hiz, pin});
    @(posedge clk_i);
    dc <= 1'b1;
    repeat (CN - 3) @(negedge clk_i);
    chk(32'h1, {31'h0, pin});
    wait_for(2, 1'b0, 8);
    chk(32'h1, {31'h0, st[ldfs_pkg::ST_DC]});
    @(posedge clk_i);
    dc <= 1'b0;
    wait_for(1, 1'b1, 4);
    $display("test open_dc done");

    for (k = 2; k < 5; k++) begin
      wait_for(0, 1'b0, DN + 8);
      @(posedge clk_i);
      load <= k[2:0];
      oc_pulse();
      // pin is pulled once all five check passes have seen the fault
      cyc(5 * DN + 5);
      @(negedge clk_i);
      chk(32'h5, {29'h0, hiz, pin, st[k - 2 + (k == 4)]});
      wait_for(1, 1'b1, DN + 4);
      @(posedge clk_i);
      load <= 3'h0;
      wait_for(0, 1'b0, 2 * DN + 10);
      wait_for(2, 1'b1, 4);
    end
    @(posedge clk_i);
    load <= 3'h5;
    oc_pulse();
    cyc(3 * DN);
    @(negedge clk_i);
    chk(32'h1, {31'h0, hiz});
    @(posedge clk_i);
    load <= 3'h0;
    wait_for(0, 1'b0, 7 * DN + 10);
    $display("test hard_loads done");

    wr_limit(2'h3);
    cyc(2);
    chk(32'h3, {30'h0, lim});
    uv <= 1'b1;
    wait_for(2, 1'b0, 4);
    wr_limit(2'h2);
    cyc(2);
    chk(32'h0, {22'h0, lim, st});
    uv <= 1'b0;
    wait_for(0, 1'b0, 2 * DN + 10);
    @(posedge clk_i);
    por <= 1'b1;
    wait_for(3, 1'b1, 3);
    chk(32'h1, {31'h0, hiz});
    cyc(1);
    por <= 1'b0;
    wait_for(1, 1'b1, 4);
    @(posedge clk_i);
    hold <= 1'b1;
    ov <= 1'b1;
    wait_for(2, 1'b0, 4);
    @(posedge clk_i);
    ov <= 1'b0;
    $display("test uv_por done");
    finish_test();
  end
endmodule
